// >>> core/bdar_defs.svh
// Purpose: Constants for the button debounce and auto-repeat block
// Assumes: 100 MHz core_clk
// Notes: Debounce time counted in core_clk cycles
`ifndef BDAR_DEFS_SVH
`define BDAR_DEFS_SVH
`define BDAR_CLK_MHZ 100
`define BDAR_DEB_US 10
`define BDAR_DEB_CYC (`BDAR_DEB_US * `BDAR_CLK_MHZ)
`define BDAR_WS_RST 8'h00
`endif

// >>> core/bdar_pkg.sv
// Purpose: Types for the button debounce and auto-repeat block
// Assumes: Nothing
// Notes: One-hot evaluation states
package bdar_pkg;
  typedef enum logic [2:0] {
    BDAR_IDLE = 3'b001,
    BDAR_SETTLE = 3'b010,
    BDAR_DONE = 3'b100
  } bdar_state_t;
endpackage

// >>> core/bdar_settle.sv
// Purpose: Settle timer, checks a pin holds its level for a time
// Assumes: Start pulses only when idle
// Notes: Result pulse reports whether level held throughout
`timescale 1ns/1ps
`include "bdar_defs.svh"
module bdar_settle #(
  parameter int CYCLES = `BDAR_DEB_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic level,
  output logic done,
  output logic stable
);
  logic [15:0] cnt_r;
  logic busy_r;
  logic ok_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      busy_r <= 1'b0;
      ok_r <= 1'b0;
      done <= 1'b0;
      stable <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        ok_r <= 1'b1;
        cnt_r <= 16'(CYCLES - 1);
      end else if (busy_r) begin
        if (!level) begin
          ok_r <= 1'b0;
        end
        if (cnt_r == 16'h0000) begin
          busy_r <= 1'b0;
          done <= 1'b1;
          stable <= ok_r & level;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end
endmodule // bdar_settle

// >>> core/bdar_top.sv
// Purpose: Button debounce with keyboard-like auto-repeat
// Assumes: Pins synchronous to core_clk; eval is a one-cycle strobe
// Notes: Caller holds the workspace byte and feeds it back
//
// Contract
// - Sample selected pin 0 to 7 on evaluate
// - Pressed level setting picks active pin level
// - Branch state selects pressed or not pressed
// - First match debounces then branches if target
// - Later pressed evaluations increment workspace
// - Delay match branches, clears; then rate match
// - Delay and rate are byte evaluation counts
// - Evaluate only on request; caller loops
`timescale 1ns/1ps
`include "bdar_defs.svh"
module bdar_top #(
  parameter int PINS = 8,
  parameter int DEB_CYCLES = `BDAR_DEB_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [PINS-1:0] pins,
  input wire logic [2:0] pin_sel,
  input wire logic down_level,
  input wire logic target_state,
  input wire logic [7:0] delay_cnt,
  input wire logic [7:0] rate_cnt,
  input wire logic [7:0] ws_in,
  input wire logic eval,
  output logic busy,
  output logic done,
  output logic branch,
  output logic [7:0] ws_out
);
  import bdar_pkg::*;

  bdar_state_t state_r;
  logic pressed;
  logic settle_done;
  logic settle_ok;
  logic settle_go;
  logic repeat_r;
  logic held_r;
  logic hit_r;
  logic [7:0] ws_r;
  logic tgt_r;
  logic [2:0] sel_r;
  logic lvl_r;
  logic [7:0] dly_r;
  logic [7:0] rate_r;
  logic [7:0] ws_inc;
  logic [7:0] thr;

  assign pressed = (pins[sel_r] == lvl_r);
  assign busy = (state_r != BDAR_IDLE);
  assign settle_go = (state_r == BDAR_IDLE) && eval
    && (pins[pin_sel] == down_level) && (ws_in == `BDAR_WS_RST)
    && !repeat_r && !held_r;
  assign ws_inc = ws_r + 8'h01;
  assign thr = repeat_r ? rate_r : dly_r;

  bdar_settle #(.CYCLES(DEB_CYCLES)) u_settle (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(settle_go),
    .level(pressed),
    .done(settle_done),
    .stable(settle_ok)
  );

  // Evaluation sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= BDAR_IDLE;
      done <= 1'b0;
      branch <= 1'b0;
      ws_out <= `BDAR_WS_RST;
      ws_r <= `BDAR_WS_RST;
      repeat_r <= 1'b0;
      held_r <= 1'b0;
      hit_r <= 1'b0;
      tgt_r <= 1'b0;
      sel_r <= 3'h0;
      lvl_r <= 1'b0;
      dly_r <= 8'h00;
      rate_r <= 8'h00;
    end else begin
      done <= 1'b0;
      branch <= 1'b0;
      unique case (state_r)
        BDAR_IDLE: begin
          if (eval) begin
            sel_r <= pin_sel;
            hit_r <= (pins[pin_sel] == down_level);
            lvl_r <= down_level;
            tgt_r <= target_state;
            dly_r <= delay_cnt;
            rate_r <= rate_cnt;
            ws_r <= ws_in;
            state_r <= settle_go ? BDAR_SETTLE : BDAR_DONE;
          end
        end
        BDAR_SETTLE: begin
          if (settle_done) begin
            done <= 1'b1;
            branch <= settle_ok ? tgt_r : ~tgt_r;
            held_r <= settle_ok;
            ws_out <= `BDAR_WS_RST;
            state_r <= BDAR_IDLE;
          end
        end
        BDAR_DONE: begin
          done <= 1'b1;
          state_r <= BDAR_IDLE;
          if (!hit_r) begin
            repeat_r <= 1'b0;
            held_r <= 1'b0;
            branch <= ~tgt_r;
            ws_out <= `BDAR_WS_RST;
          end else if (ws_inc == thr) begin
            branch <= tgt_r;
            repeat_r <= 1'b1;
            ws_out <= `BDAR_WS_RST;
          end else begin
            ws_out <= ws_inc;
          end
        end
      endcase
    end
  end

  property p_done_pulse;
    @(posedge core_clk) disable iff (!rstn)
      done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");

  property p_branch_with_done;
    @(posedge core_clk) disable iff (!rstn)
      branch |-> done;
  endproperty
  a_branch_with_done: assert property (p_branch_with_done)
    else $error("branch without done");

  property p_eval_answers;
    @(posedge core_clk) disable iff (!rstn)
      (eval && !busy && !settle_go) |=> ##1 done;
  endproperty
  a_eval_answers: assert property (p_eval_answers)
    else $error("evaluation not answered");

  property p_no_eval_no_done;
    @(posedge core_clk) disable iff (!rstn)
      (!busy && !eval) |=> !done;
  endproperty
  a_no_eval_no_done: assert property (p_no_eval_no_done)
    else $error("done without request");

  property p_incr;
    @(posedge core_clk) disable iff (!rstn)
      (state_r == BDAR_DONE && hit_r && ws_inc != thr)
        |=> (ws_out == $past(ws_r) + 8'h01) && !branch;
  endproperty
  a_incr: assert property (p_incr)
    else $error("workspace not incremented");

  property p_thr_branch;
    @(posedge core_clk) disable iff (!rstn)
      (state_r == BDAR_DONE && hit_r && ws_inc == thr)
        |=> ws_out == 8'h00 && branch == $past(tgt_r);
  endproperty
  a_thr_branch: assert property (p_thr_branch)
    else $error("threshold branch wrong");

  property p_release;
    @(posedge core_clk) disable iff (!rstn)
      (state_r == BDAR_DONE && !hit_r)
        |=> branch == !$past(tgt_r) && ws_out == 8'h00;
  endproperty
  a_release: assert property (p_release)
    else $error("release branch wrong");

  property p_settle_branch;
    @(posedge core_clk) disable iff (!rstn)
      (state_r == BDAR_SETTLE && settle_done && settle_ok)
        |=> branch == $past(tgt_r);
  endproperty
  a_settle_branch: assert property (p_settle_branch)
    else $error("debounced press branch wrong");

  property p_settle_bounce;
    @(posedge core_clk) disable iff (!rstn)
      (state_r == BDAR_SETTLE && settle_done && !settle_ok)
        |=> branch == !$past(tgt_r) && ws_out == 8'h00;
  endproperty
  a_settle_bounce: assert property (p_settle_bounce)
    else $error("bounced press branch wrong");

  property p_settle_done;
    @(posedge core_clk) disable iff (!rstn)
      (state_r == BDAR_SETTLE && settle_done) |=> done && !busy;
  endproperty
  a_settle_done: assert property (p_settle_done)
    else $error("debounce end not answered");

  property p_one_sample;
    @(posedge core_clk) disable iff (!rstn)
      (eval && !busy && (pins[pin_sel] == down_level)) |=> hit_r;
  endproperty
  a_one_sample: assert property (p_one_sample)
    else $error("pressed pin not sampled");

  property p_hold_skip;
    @(posedge core_clk) disable iff (!rstn)
      (eval && !busy && held_r) |=> state_r == BDAR_DONE;
  endproperty
  a_hold_skip: assert property (p_hold_skip)
    else $error("held press debounced again");

  c_first: cover property (@(posedge core_clk) settle_go);
  c_repeat: cover property (@(posedge core_clk)
    state_r == BDAR_DONE && repeat_r && hit_r && ws_inc == thr);
  c_delay: cover property (@(posedge core_clk)
    state_r == BDAR_DONE && !repeat_r && hit_r && ws_inc == thr);
  c_held_incr: cover property (@(posedge core_clk)
    state_r == BDAR_DONE && held_r && !repeat_r && hit_r);
endmodule // bdar_top

// >>> verification/bdar_switch.sv
// Purpose: Push-button model on the selected input pin
// Assumes: Unselected pins rest at the released level
// Notes: Chatter starts open, then flips the contact every cycle
`timescale 1ns/1ps
module bdar_switch (
  input wire logic core_clk,
  input wire logic [2:0] pin_sel,
  input wire logic down_level,
  input wire logic press,
  input wire logic chatter,
  output logic [7:0] pins
);
  logic flip_r;
  always_ff @(posedge core_clk) begin
    flip_r <= chatter ? ~flip_r : 1'b1;
  end
  always_comb begin
    pins = {8{~down_level}};
    pins[pin_sel] = press ^ (chatter & flip_r) ? down_level : ~down_level;
  end
endmodule // bdar_switch

// >>> verification/bdar_top_test.sv
// Purpose: Self-checking bench for the debounce and auto-repeat block
// Assumes: Bench drives ws_in each evaluation, not always the last ws_out
// Notes: Debounce shortened to 4 cycles
`timescale 1ns/1ps
module bdar_top_test;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] pins;
  logic [2:0] pin_sel = 3'h0;
  logic down_level = 1'b0;
  logic target_state = 1'b1;
  logic [7:0] delay_cnt = 8'h03;
  logic [7:0] rate_cnt = 8'h02;
  logic [7:0] ws_in = 8'h00;
  logic eval = 1'b0;
  logic press = 1'b0;
  logic chatter = 1'b0;
  logic busy, done, branch;
  logic [7:0] ws_out;
  int n_errors = 0;
  int checked = 0;
  always #5 core_clk = ~core_clk;
  bdar_switch bdar_switch_i (.core_clk(core_clk), .pin_sel(pin_sel),
    .down_level(down_level), .press(press), .chatter(chatter),
    .pins(pins));
  bdar_top #(.DEB_CYCLES(4)) bdar_top_i (.core_clk(core_clk),
    .rstn(rstn), .pins(pins), .pin_sel(pin_sel),
    .down_level(down_level), .target_state(target_state),
    .delay_cnt(delay_cnt), .rate_cnt(rate_cnt), .ws_in(ws_in),
    .eval(eval), .busy(busy), .done(done), .branch(branch),
    .ws_out(ws_out));
  task automatic results();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One evaluation, answer awaited under a bound
  task automatic ev(logic [7:0] ws, logic eb, logic [7:0] ew);
    int i;
    @(negedge core_clk);
    chk("idle busy", 8'h00, {7'h00, busy});
    ws_in = ws;
    eval = 1'b1;
    @(negedge core_clk);
    eval = 1'b0;
    chk("busy", 8'h01, {7'h00, busy});
    for (i = 0; i < 20 && done !== 1'b1; i++)
      @(negedge core_clk);
    chk("done", 8'h01, {7'h00, done});
    if (done !== 1'b1)
      results();
    chk("branch", {7'h00, eb}, {7'h00, branch});
    chk("ws_out", ew, ws_out);
  endtask
  initial begin
    int p;
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    chk("ws_out", 8'h00, ws_out);
    for (p = 0; p < 8; p++) begin
      @(negedge core_clk);
      chk("idle done", 8'h00, {7'h00, done});
    end
    $display("test idle ended");
    for (p = 0; p < 16; p++) begin
      pin_sel = p[2:0];
      down_level = p[3];
      target_state = p[0];
      press = 1'b1;
      ev(8'h00, p[0], 8'h00);
      press = 1'b0;
      ev(8'h00, ~p[0], 8'h00);
    end
    $display("test pins ended");
    press = 1'b1;
    chatter = 1'b1;
    ev(8'h00, 1'b0, 8'h00);
    chatter = 1'b0;
    $display("test chatter ended");
    ev(8'h00, 1'b1, 8'h00);
    ev(8'h00, 1'b0, 8'h01);
    ev(8'h01, 1'b0, 8'h02);
    ev(8'h02, 1'b1, 8'h00);
    ev(8'h00, 1'b0, 8'h01);
    ev(8'h01, 1'b1, 8'h00);
    press = 1'b0;
    ev(8'h01, 1'b0, 8'h00);
    press = 1'b1;
    ev(8'h05, 1'b0, 8'h06);
    delay_cnt = 8'hff;
    ev(8'hfe, 1'b1, 8'h00);
    $display("test repeat ended");
    results();
  end
endmodule // bdar_top_test
